// ---- src/extended_instruction_exec.sv ----
// Decode and execute logic for the eight-instruction extension of an 8-bit core
`timescale 1ns/1ps
// Functional notes
// RULE_01: Add-literal with pointer 0..2 adds 6-bit literal to pointer, one cycle.
// RULE_02: Add-literal with field 11 adds to pointer 2 then returns from stack top.
// RULE_03: Add/subtract-and-return take two cycles, second a forced no-operation.
// RULE_04: Subtract-literal with pointer 0..2 subtracts 6-bit literal, one cycle.
// RULE_05: Subtract-literal with field 11 subtracts from pointer 2 then returns.
// RULE_06: Call via working register pushes next address, loads counter from latches.
// RULE_07: Call via working register takes two cycles, second a no-operation.
// RULE_08: Call via working register saves no working, status or bank register.
// RULE_09: Indexed-to-file move: source pointer 2 plus offset, 12-bit destination.
// RULE_10: Indexed-to-indexed move: both addresses pointer 2 plus 7-bit offsets.
// RULE_11: Computed move addresses cover the full 4096-byte data space.
// RULE_12: Software never names counter low or stack top bytes as move destination.
// RULE_13: Move source on an indirect register delivers zero.
// RULE_14: Indexed move destination on indirect register suppresses the write.
// RULE_15: Push-literal writes literal at pointer 2, then decrements pointer 2.
// RULE_16: Extension acts only when enable bit set; default disabled.
// RULE_17: No extension instruction modifies any status flag.
// RULE_18: Pointer arithmetic uses full pointer width with carry into high byte.
module extended_instruction_exec
	import ext_exec_pkg::*;
(
	// Clock and reset
	input  wire logic                           sys_clk_i,
	input  wire logic                           sys_rst_i,
	// Configuration and instruction stream
	input  wire logic                           ext_enable_i,
	input  wire logic                           instr_valid_i,
	input  wire logic [ext_exec_pkg::INSTR_W-1:0] instr_i,
	// Core state
	input  wire logic [ext_exec_pkg::PC_W-1:0]  pc_i,
	input  wire logic [ext_exec_pkg::DATA_W-1:0] working_register_i,
	input  wire logic [ext_exec_pkg::DATA_W-1:0] counter_latch_high_i,
	input  wire logic [ext_exec_pkg::DATA_W-1:0] counter_latch_upper_i,
	input  wire logic [ext_exec_pkg::PC_W-1:0]  return_stack_top_i,
	// Data memory read answer
	input  wire logic [ext_exec_pkg::DATA_W-1:0] mem_rdata_i,
	// File-select pointers
	output logic [ext_exec_pkg::ADDR_W-1:0]     ptr0_o,
	output logic [ext_exec_pkg::ADDR_W-1:0]     ptr1_o,
	output logic [ext_exec_pkg::ADDR_W-1:0]     frame_pointer_two_o,
	// Program counter and return stack
	output logic                                pc_load_o,
	output logic [ext_exec_pkg::PC_W-1:0]       pc_value_o,
	output logic                                stack_push_o,
	output logic [ext_exec_pkg::PC_W-1:0]       stack_push_value_o,
	output logic                                stack_pop_o,
	// Data memory
	output logic                                mem_rd_o,
	output logic [ext_exec_pkg::ADDR_W-1:0]     mem_raddr_o,
	output logic                                mem_wr_o,
	output logic [ext_exec_pkg::ADDR_W-1:0]     mem_waddr_o,
	output logic [ext_exec_pkg::DATA_W-1:0]     mem_wdata_o,
	// Pipeline status
	output logic                                ext_hit_o,
	output logic                                busy_o,
	output logic                                flags_write_o
);

	exec_state_t                state_q;
	logic                       enable_meta_q;
	logic                       enable_q;
	logic [ADDR_W-1:0]          ptr_q [3];
	logic [DATA_W-1:0]          move_data_q;
	logic [ADDR_W-1:0]          src_addr;
	logic [ADDR_W-1:0]          dst_addr;
	logic                       is_add;
	logic                       is_sub;
	logic                       is_push;
	logic                       is_move;
	logic                       is_call;
	logic                       is_return;
	logic [1:0]                 sel;
	logic [ADDR_W-1:0]          lit6;
	logic                       first_ok;
	// Source byte as it leaves the read stage, already cleared for indirect registers
	logic [DATA_W-1:0]          src_byte;
	logic                       src_indirect;

	// Enable strap comes from configuration, so it is synchronised
	// The extension resets to disabled and waits for two clean samples
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			enable_meta_q <= 1'b0;
			enable_q      <= 1'b0; // RULE_16
		end else begin
			enable_meta_q <= ext_enable_i;
			enable_q      <= enable_meta_q;
		end
	end

	// Decode of first words, only while idle and enabled
	// A busy cycle refuses every word, so a second move word never decodes as a first
	assign first_ok  = instr_valid_i && enable_q && (state_q == ST_IDLE); // RULE_16
	assign sel       = instr_i[7:6];
	assign lit6      = {6'h00, instr_i[5:0]};
	assign is_add    = first_ok && (instr_i[15:8] == OP_ADD_PTR);
	assign is_sub    = first_ok && (instr_i[15:8] == OP_SUB_PTR);
	assign is_push   = first_ok && (instr_i[15:8] == OP_PUSH_LIT);
	assign is_move   = first_ok && (instr_i[15:8] == OP_MOVE_IDX);
	assign is_call   = first_ok && (instr_i == OP_CALL_W);
	// Pointer field 11 turns add and subtract into their returning forms
	assign is_return = (is_add || is_sub) && (sel == PTR_RETURN); // RULE_02 RULE_05
	assign ext_hit_o = is_add || is_sub || is_push || is_move || is_call;
	assign busy_o    = (state_q != ST_IDLE);
	assign flags_write_o = 1'b0; // RULE_17 RULE_08

	// Source is pointer 2 plus offset, 12-bit wrap covers whole data space
	assign src_addr = ptr_q[2] + {5'h00, instr_i[6:0]}; // RULE_09 RULE_11
	// Second word destination: absolute or pointer 2 plus offset
	assign dst_addr = (state_q == ST_MOVEF) ? instr_i[11:0]
		: ptr_q[2] + {5'h00, instr_i[6:0]}; // RULE_10 RULE_11

	// Instruction-cycle sequencing
	// Returns and calls spend one flush cycle: the word fetched behind them is dropped
	// while the core fetches from the new target
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (is_return || is_call)
						state_q <= ST_FLUSH; // RULE_03 RULE_07
					else if (is_move)
						state_q <= instr_i[7] ? ST_MOVES : ST_MOVEF;
				end
				ST_FLUSH: state_q <= ST_IDLE;
				// Any valid word ends a move; a malformed one writes nothing
				ST_MOVEF, ST_MOVES: begin
					if (instr_valid_i)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Pointer updates at full width, carry reaches the high part
	// Twelve bits match the data space, so pointer sums wrap with no bank limit
	for (genvar i = 0; i < 3; i++) begin : g_ptr
		always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				ptr_q[i] <= PTR_RESET;
			end else if (is_add && (sel == 2'(i) || (is_return && i == 2))) begin
				ptr_q[i] <= ptr_q[i] + lit6; // RULE_01 RULE_02 RULE_18
			end else if (is_sub && (sel == 2'(i) || (is_return && i == 2))) begin
				ptr_q[i] <= ptr_q[i] - lit6; // RULE_04 RULE_05 RULE_18
			end else if (is_push && i == 2) begin
				ptr_q[i] <= ptr_q[i] - 12'h001; // RULE_15
			end
		end
	end
	// Pointer outputs straight from the flops
	assign ptr0_o              = ptr_q[0];
	assign ptr1_o              = ptr_q[1];
	assign frame_pointer_two_o = ptr_q[2];

	// Source byte: the live answer while the read stands, the held copy afterwards.
	// Taking the live answer lets a second word that follows at once write the fresh byte.
	assign src_indirect = (mem_raddr_o >= INDIRECT_LO) && (mem_raddr_o <= INDIRECT_HI);
	assign src_byte     = src_indirect ? 8'h00 // RULE_13
		: (mem_rd_o ? mem_rdata_i : move_data_q);

	// Held source byte for a second word that arrives late
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			move_data_q <= 8'h00;
		else if (mem_rd_o)
			move_data_q <= src_byte;
	end

	// Registered outputs to counter, stack and memory
	// The call only pushes and loads the counter; no core register is saved or restored
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pc_load_o          <= 1'b0;
			pc_value_o         <= '0;
			stack_push_o       <= 1'b0;
			stack_push_value_o <= '0;
			stack_pop_o        <= 1'b0;
			mem_rd_o           <= 1'b0;
			mem_raddr_o        <= '0;
			mem_wr_o           <= 1'b0;
			mem_waddr_o        <= '0;
			mem_wdata_o        <= 8'h00;
		end else begin
			pc_load_o    <= is_return || is_call;
			stack_pop_o  <= is_return; // RULE_02 RULE_05
			stack_push_o <= is_call; // RULE_06
			mem_rd_o     <= is_move;
			mem_wr_o     <= 1'b0;
			if (is_return)
				pc_value_o <= return_stack_top_i;
			else if (is_call) begin
				pc_value_o         <= {counter_latch_upper_i[4:0], counter_latch_high_i,
					working_register_i}; // RULE_06
				stack_push_value_o <= pc_i + PC_STEP;
			end
			if (is_move)
				mem_raddr_o <= src_addr;
			// Push writes at the old pointer 2; the pointer steps down at the same edge
			if (is_push) begin
				mem_wr_o    <= 1'b1; // RULE_15
				mem_waddr_o <= ptr_q[2];
				mem_wdata_o <= instr_i[7:0];
			end else if (instr_valid_i && instr_i[15:12] == OP_SECOND
				&& (state_q == ST_MOVEF || state_q == ST_MOVES)) begin
				// Indexed destination on an indirect register becomes a no-operation
				mem_wr_o    <= !(state_q == ST_MOVES && dst_addr >= INDIRECT_LO
					&& dst_addr <= INDIRECT_HI); // RULE_14
				mem_waddr_o <= dst_addr; // RULE_09 RULE_10
				mem_wdata_o <= src_byte; // RULE_13
			end
		end
	end

endmodule // extended_instruction_exec

// ---- inc/ext_exec_pkg.sv ----
// Package of constants for the extended instruction decode and execute block
package ext_exec_pkg;
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 8;
	localparam int          PC_W        = 21;
	localparam int          INSTR_W     = 16;
	// Opcode fields
	localparam logic [7:0]  OP_ADD_PTR  = 8'hE8;
	localparam logic [7:0]  OP_SUB_PTR  = 8'hE9;
	localparam logic [7:0]  OP_PUSH_LIT = 8'hEA;
	localparam logic [7:0]  OP_MOVE_IDX = 8'hEB;
	localparam logic [3:0]  OP_SECOND   = 4'hF;
	localparam logic [15:0] OP_CALL_W   = 16'h0014;
	localparam logic [1:0]  PTR_RETURN  = 2'h3;
	// Indirect-access registers in the data space
	localparam logic [11:0] INDIRECT_LO = 12'hFDB;
	localparam logic [11:0] INDIRECT_HI = 12'hFEF;
	localparam logic [11:0] PTR_RESET   = 12'h000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
	// Instruction-cycle state
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FLUSH = 4'b0010,
		ST_MOVEF = 4'b0100,
		ST_MOVES = 4'b1000
	} exec_state_t;
endpackage

// ---- verification/ext_mem_model.sv ----
// Data memory partner model for the extension block
`timescale 1ns/1ps
module ext_mem_model
	import ext_exec_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              mem_rd_o,
	input  wire logic [ADDR_W-1:0] mem_raddr_o,
	input  wire logic              mem_wr_o,
	input  wire logic [ADDR_W-1:0] mem_waddr_o,
	input  wire logic [DATA_W-1:0] mem_wdata_o,
	output logic      [DATA_W-1:0] mem_rdata_i
);
	logic [DATA_W-1:0] mem [0:4095];
	logic              rd_q;
	// Write port and read window tracking
	always @(posedge sys_clk_i) begin
		if (mem_wr_o) mem[mem_waddr_o] <= mem_wdata_o;
		rd_q <= mem_rd_o;
	end
	// Outside a read window the answer is inverted so stale data never passes
	assign mem_rdata_i = (mem_rd_o || rd_q) ? mem[mem_raddr_o] : ~mem[mem_raddr_o];
endmodule // ext_mem_model

// ---- verification/ext_exec_asserts.sv ----
// Port-level checks for the extension decode and execute block
`timescale 1ns/1ps
module ext_exec_asserts
	import ext_exec_pkg::*;
(
	input wire logic               sys_clk_i,
	input wire logic               sys_rst_i,
	input wire logic               ext_enable_i,
	input wire logic [INSTR_W-1:0] instr_i,
	input wire logic [PC_W-1:0]    return_stack_top_i,
	input wire logic [ADDR_W-1:0]  ptr0_o,
	input wire logic [ADDR_W-1:0]  frame_pointer_two_o,
	input wire logic               pc_load_o,
	input wire logic [PC_W-1:0]    pc_value_o,
	input wire logic               mem_wr_o,
	input wire logic [DATA_W-1:0]  mem_wdata_o,
	input wire logic               ext_hit_o,
	input wire logic               busy_o,
	input wire logic               flags_write_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [ADDR_W-1:0] lit;
	assign lit = {6'h00, instr_i[5:0]};
	// Pointer arithmetic, returns, call and return length, push, flags and enable
	flags_never_a: assert property (flags_write_o == 1'b0)
		else $error("status flag write seen");
	add_ptr_a: assert property (ext_hit_o && instr_i[15:6] == {OP_ADD_PTR, 2'b00}
		|=> ptr0_o == $past(ptr0_o) + $past(lit)) else $error("pointer add wrong");
	sub_ptr_a: assert property (ext_hit_o && instr_i[15:6] == {OP_SUB_PTR, 2'b00}
		|=> ptr0_o == $past(ptr0_o) - $past(lit)) else $error("pointer subtract wrong");
	add_return_a: assert property (ext_hit_o && instr_i[15:6] == {OP_ADD_PTR, PTR_RETURN}
		|=> pc_load_o && pc_value_o == $past(return_stack_top_i)
		&& frame_pointer_two_o == $past(frame_pointer_two_o) + $past(lit)) else $error("add return");
	sub_return_a: assert property (ext_hit_o && instr_i[15:6] == {OP_SUB_PTR, PTR_RETURN}
		|=> pc_load_o && pc_value_o == $past(return_stack_top_i)
		&& frame_pointer_two_o == $past(frame_pointer_two_o) - $past(lit)) else $error("sub return");
	two_cycle_a: assert property (ext_hit_o && (instr_i == OP_CALL_W || instr_i[7:6] == PTR_RETURN
		&& instr_i[15:9] == OP_ADD_PTR[7:1]) |=> busy_o ##1 !busy_o) else $error("length wrong");
	push_lit_a: assert property (ext_hit_o && instr_i[15:8] == OP_PUSH_LIT |=> mem_wr_o
		&& mem_wdata_o == $past(instr_i[7:0])
		&& frame_pointer_two_o == $past(frame_pointer_two_o) - 12'h001) else $error("push wrong");
	disabled_a: assert property (!ext_enable_i [*3] |-> !ext_hit_o)
		else $error("decode while disabled");
	// Main scenarios reached
	call_c: cover property (ext_hit_o && instr_i == OP_CALL_W);
	push_c: cover property (ext_hit_o && instr_i[15:8] == OP_PUSH_LIT);
	move_c: cover property (ext_hit_o && instr_i[15:8] == OP_MOVE_IDX);
	return_c: cover property (ext_hit_o && instr_i[7:6] == PTR_RETURN
		&& instr_i[15:9] == OP_ADD_PTR[7:1]);
endmodule // ext_exec_asserts
bind extended_instruction_exec ext_exec_asserts u_asserts (.*);

// ---- verification/tb.sv ----
// Self-checking bench for the extension decode and execute block
`timescale 1ns/1ps
module tb;
	import ext_exec_pkg::*;
	logic sys_clk_i = 0, sys_rst_i = 1, ext_enable_i = 1, instr_valid_i = 0;
	logic [INSTR_W-1:0] instr_i = '0;
	logic [PC_W-1:0] pc_i = 21'h00_0100, return_stack_top_i = 21'h00_0200, pc_value_o;
	logic [PC_W-1:0] stack_push_value_o;
	logic [DATA_W-1:0] working_register_i = 8'h06, counter_latch_high_i = 8'h10;
	logic [DATA_W-1:0] counter_latch_upper_i = 8'h00, mem_rdata_i, mem_wdata_o;
	logic [ADDR_W-1:0] ptr0_o, ptr1_o, frame_pointer_two_o, mem_raddr_o, mem_waddr_o;
	logic pc_load_o, stack_push_o, stack_pop_o, mem_rd_o, mem_wr_o, ext_hit_o, busy_o;
	logic flags_write_o;
	int mismatches = 0, check_count = 0;
	// Instruction word, pointer select, pointer value expected after it
	logic [29:0] rows [5] = '{{16'hE805, 2'd0, 12'h005}, {16'hE84A, 2'd1, 12'h00A},
		{16'hE901, 2'd0, 12'h004}, {16'hE950, 2'd1, 12'hFFA}, {16'hE9B0, 2'd2, 12'hFD0}};
	extended_instruction_exec u_dut (.*);
	ext_mem_model u_mem (.*);
	initial forever #10 sys_clk_i = ~sys_clk_i;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One word, taken at the next edge
	task automatic exec(input logic [15:0] w);
		@(posedge sys_clk_i);
		#1 instr_valid_i = 1;
		instr_i = w;
		@(posedge sys_clk_i);
		#1 instr_valid_i = 0;
	endtask
	// Two-word move, checks the read it issues, returns once its write has landed
	task automatic mv(input logic [15:0] w1, input logic [15:0] w2, input logic [11:0] src);
		@(posedge sys_clk_i);
		#1 instr_valid_i = 1;
		instr_i = w1;
		@(posedge sys_clk_i);
		#1 instr_i = w2;
		check({mem_rd_o, mem_raddr_o}, {1'b1, src});
		@(posedge sys_clk_i);
		#1 instr_valid_i = 0;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic summarize;
		if (mismatches == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		u_mem.mem[12'h000] = 8'hAA;
		u_mem.mem[12'h010] = 8'h33;
		u_mem.mem[12'hFDB] = 8'h5A;
		repeat (3) @(posedge sys_clk_i);
		#1 sys_rst_i = 0;
		check({ptr0_o, frame_pointer_two_o, pc_load_o, mem_wr_o}, 0);
		repeat (3) @(posedge sys_clk_i);
		foreach (rows[i]) begin
			exec(rows[i][29:14]);
			check(rows[i][13:12] == 0 ? ptr0_o : rows[i][13:12] == 1 ? ptr1_o
				: frame_pointer_two_o, rows[i][11:0]);
		end
		// Destinations below avoid counter and stack-top bytes
		mv(16'hEB8B, 16'hF030, 12'hFDB);
		check(u_mem.mem[12'h000], 8'h00);
		mv(16'hEBB0, 16'hF00B, 12'h000);
		check(u_mem.mem[12'hFDB], 8'h5A);
		mv(16'hEBC0, 16'hF041, 12'h010);
		check(u_mem.mem[12'h011], 8'h33);
		mv(16'hEB40, 16'hF123, 12'h010);
		check(u_mem.mem[12'h123], 8'h33);
		exec(16'hEA08);
		check({frame_pointer_two_o, mem_waddr_o, mem_wdata_o}, {12'hFCF, 12'hFD0, 8'h08});
		exec(16'h0014);
		check({pc_load_o, stack_push_o, stack_pop_o, busy_o, flags_write_o}, 5'b11010);
		check({pc_value_o, stack_push_value_o}, {21'h00_1006, 21'h00_0102});
		// A word offered in the flush cycle after a call is dropped
		@(posedge sys_clk_i);
		#1 instr_valid_i = 1;
		instr_i = 16'h0014;
		@(posedge sys_clk_i);
		#1 instr_i = 16'hEA08;
		@(posedge sys_clk_i);
		#1 instr_valid_i = 0;
		check({mem_wr_o, frame_pointer_two_o}, {1'b0, 12'hFCF});
		exec(16'hE8C3);
		check({pc_load_o, stack_pop_o, busy_o, pc_value_o}, {3'b111, 21'h00_0200});
		check(frame_pointer_two_o, 12'hFD2);
		exec(16'hE9C3);
		check({pc_load_o, stack_pop_o, frame_pointer_two_o}, {2'b11, 12'hFCF});
		ext_enable_i = 0;
		repeat (3) @(posedge sys_clk_i);
		exec(16'hE805);
		check({ptr0_o, flags_write_o}, {12'h004, 1'b0});
		summarize();
	end
	// Watchdog against a hang
	initial begin
		repeat (1000) @(posedge sys_clk_i);
		mismatches++;
		summarize();
	end
endmodule // tb
